/* inc/adcc_params.svh */
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define ADCC_OFF_CTRL    8'h00
`define ADCC_OFF_RPT     8'h04
`define ADCC_OFF_THRESH  8'h08
`define ADCC_OFF_STATUS  8'h0c
`define ADCC_OFF_ACC     8'h10
`define ADCC_OFF_CNT     8'h14
`define ADCC_OFF_FLTR    8'h18
`define ADCC_OFF_RES     8'h1c

// ****************************************************************
// Control register fields
// ****************************************************************
`define ADCC_CTRL_MODE_LSB   0
`define ADCC_CTRL_MODE_MSB   2
`define ADCC_CTRL_DSEN_BIT   3
`define ADCC_CTRL_RCSEL_BIT  4
`define ADCC_CTRL_GO_BIT     5
`define ADCC_CTRL_ACLR_BIT   6
`define ADCC_CTRL_CS_LSB     8
`define ADCC_CTRL_CS_MSB     13
`define ADCC_CTRL_SHIFT_LSB  16
`define ADCC_CTRL_SHIFT_MSB  18

// Status register fields
`define ADCC_STAT_TIF_BIT    0
`define ADCC_STAT_OVF_BIT    1

// ****************************************************************
// Reset values and counter saturation limit
// ****************************************************************
`define ADCC_RST_CS      6'h00
`define ADCC_RST_SHIFT   3'h0
`define ADCC_RST_RPT     8'h00
`define ADCC_CNT_MAX     8'hff

// ****************************************************************
// Conversion clock divider
// ****************************************************************
`define ADCC_CS_DIV2     6'h00
`define ADCC_CS_DIV4     6'h01
`define ADCC_CS_DIV6     6'h02
`define ADCC_CS_DIV8     6'h03
`define ADCC_CS_DIV16    6'h04
`define ADCC_CS_DIV128   6'h3f

`endif

/* inc/adcc_pkg.sv */
package adcc_pkg;

    // Computation mode codes
    typedef enum logic [2:0] {
        ADCC_MODE_BASIC,
        ADCC_MODE_ACCUM,
        ADCC_MODE_AVG,
        ADCC_MODE_BURST,
        ADCC_MODE_LPF
    } adcc_mode_t;

endpackage

/* verilog/adcc_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcc_params.svh"

// Behaviour
// - The conversion clock divides the system clock by 2, 4, 6, 8, 16 for codes 0 to 4 and by 128 for code 3f.
// - With the RC select bit set the conversion clock follows the dedicated RC clock instead of the divider.
// - Basic mode leaves accumulator and counter alone apart from the clear bit and tests the threshold on every sample.
// - Accumulate mode adds each sample to the accumulator, counts up saturating at ff, and clears both on the clear bit.
// - Average mode also clears on go or retrigger with the counter at or above the target and tests only once the target is reached.
// - Burst mode clears on go or retrigger, repeats while the counter is below the target and ends with the full sum.
// - Low-pass mode sets the accumulator to sample plus accumulator minus accumulator shifted by the filter shift.
// - At the threshold interrupt modes 1 to 4 record overflow, and the filter result is the shifted accumulator or the filtered value.
// - The sample is the current result, or current minus previous when double sampling is on.
module adcc_core
    import adcc_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int ACC_W = 18
) (
    input  wire logic             CLK_SYS_I,
    input  wire logic             NRST_I,
    input  wire logic [7:0]       ADDR_I,
    input  wire logic [31:0]      WDATA_I,
    input  wire logic             WR_I,
    input  wire logic             RD_I,
    output logic      [31:0]      RDATA_O,
    input  wire logic             RC_CLK_I,
    input  wire logic             RETRIG_I,
    input  wire logic             CONV_DONE_I,
    input  wire logic [RES_W-1:0] CONV_RESULT_I,
    output logic                  CONV_CLK_EN_O,
    output logic                  CONV_START_O,
    output logic                  THRESH_IRQ_O,
    output logic                  THRESH_FLAG_O,
    output logic                  OVF_FLAG_O
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    generate
        if (RES_W < 2 || RES_W > 16 ||
            ACC_W < RES_W + 2 || ACC_W > 31) begin : g_bad
            $error("adcc_core: unsupported RES_W or ACC_W");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0]       mode;
        logic             dsen;
        logic             rcsel;
        logic [5:0]       cs;
        logic [2:0]       shift;
        logic [7:0]       rpt;
        logic [ACC_W-1:0] thresh;
        logic [7:0]       div_cnt;
        logic             rc_prev;
        logic             clk_en;
        logic [ACC_W-1:0] acc;
        logic [7:0]       cnt;
        logic [RES_W-1:0] res;
        logic [RES_W-1:0] prev;
        logic [ACC_W-1:0] fltr;
        logic             tif;
        logic             ovf;
        logic             irq;
        logic             start;
        logic [31:0]      rdata;
    } adcc_state_t;

    adcc_state_t st_reg;
    adcc_state_t st_next;

    // Divide ratio for a clock-select code
    function automatic logic [7:0] div_of(input logic [5:0] code);
        case (code)
            `ADCC_CS_DIV2:   div_of = 8'h02;
            `ADCC_CS_DIV4:   div_of = 8'h04;
            `ADCC_CS_DIV6:   div_of = 8'h06;
            `ADCC_CS_DIV8:   div_of = 8'h08;
            `ADCC_CS_DIV16:  div_of = 8'h10;
            `ADCC_CS_DIV128: div_of = 8'h80;
            default:         div_of = 8'h02;
        endcase
    endfunction

    // Sign extension of the accumulator to 32 bits for reads
    function automatic logic [31:0] ext32(input logic [ACC_W-1:0] v);
        ext32 = {{(32-ACC_W){v[ACC_W-1]}}, v};
    endfunction

    // Arithmetic shift right of the accumulator
    function automatic logic [ACC_W-1:0] acc_new_shift(
        input logic [ACC_W-1:0] v,
        input logic [2:0]       sh
    );
        acc_new_shift = $signed(v) >>> sh;
    endfunction

    logic             wr_ctrl;
    logic             go_wr;
    logic             aclr_wr;
    logic             go_evt;
    logic             clr_evt;
    logic             test_ok;
    logic             ovf_now;
    logic             is_acc;
    logic [ACC_W-1:0] acc_base;
    logic [7:0]       cnt_base;
    logic [ACC_W:0]   samp_x;
    logic [ACC_W:0]   acc_x;
    logic [ACC_W:0]   sum_x;
    logic [ACC_W-1:0] acc_sh;
    logic [ACC_W-1:0] acc_new;
    logic [7:0]       cnt_new;
    logic [ACC_W-1:0] fltr_new;
    logic [RES_W:0]   samp;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.irq   = 1'b0;
        st_next.start = 1'b0;
        st_next.rdata = 32'h0;

        // Register writes
        wr_ctrl = WR_I && (ADDR_I == `ADCC_OFF_CTRL);
        go_wr   = wr_ctrl && WDATA_I[`ADCC_CTRL_GO_BIT];
        aclr_wr = wr_ctrl && WDATA_I[`ADCC_CTRL_ACLR_BIT];
        if (wr_ctrl) begin
            st_next.mode  = WDATA_I[`ADCC_CTRL_MODE_MSB:`ADCC_CTRL_MODE_LSB];
            st_next.dsen  = WDATA_I[`ADCC_CTRL_DSEN_BIT];
            st_next.rcsel = WDATA_I[`ADCC_CTRL_RCSEL_BIT];
            st_next.cs    = WDATA_I[`ADCC_CTRL_CS_MSB:`ADCC_CTRL_CS_LSB];
            st_next.shift = WDATA_I[`ADCC_CTRL_SHIFT_MSB:`ADCC_CTRL_SHIFT_LSB];
        end
        if (WR_I && ADDR_I == `ADCC_OFF_RPT) begin
            st_next.rpt = WDATA_I[7:0];
        end
        if (WR_I && ADDR_I == `ADCC_OFF_THRESH) begin
            st_next.thresh = WDATA_I[ACC_W-1:0];
        end
        // Write one to clear; a set below in the same cycle wins
        if (WR_I && ADDR_I == `ADCC_OFF_STATUS) begin
            if (WDATA_I[`ADCC_STAT_TIF_BIT]) st_next.tif = 1'b0;
            if (WDATA_I[`ADCC_STAT_OVF_BIT]) st_next.ovf = 1'b0;
        end

        // Conversion clock enable from divider or RC clock edge
        st_next.rc_prev = RC_CLK_I;
        st_next.clk_en  = 1'b0;
        if (st_reg.rcsel) begin
            st_next.clk_en  = RC_CLK_I && !st_reg.rc_prev;
            st_next.div_cnt = 8'h00;
        end else if (st_reg.div_cnt + 8'h01 >= div_of(st_reg.cs)) begin
            st_next.clk_en  = 1'b1;
            st_next.div_cnt = 8'h00;
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 8'h01;
        end

        // Clear conditions on go, retrigger or clear bit
        go_evt  = go_wr || RETRIG_I;
        clr_evt = aclr_wr;
        if (go_evt && st_reg.mode == ADCC_MODE_AVG && st_reg.cnt >= st_reg.rpt)
            clr_evt = 1'b1;
        if (go_evt && st_reg.mode == ADCC_MODE_BURST)
            clr_evt = 1'b1;
        acc_base = clr_evt ? '0 : st_reg.acc;
        cnt_base = clr_evt ? 8'h00 : st_reg.cnt;
        if (clr_evt) begin
            st_next.acc = '0;
            st_next.cnt = 8'h00;
        end
        if (go_evt) begin
            st_next.start = 1'b1;
        end

        // Sample term: plain or double-sample difference
        samp = st_reg.dsen ? ({1'b0, CONV_RESULT_I} - {1'b0, st_reg.res})
                           : {1'b0, CONV_RESULT_I};
        samp_x = {{(ACC_W-RES_W){samp[RES_W] && st_reg.dsen}}, samp};
        acc_x  = {acc_base[ACC_W-1], acc_base};
        acc_sh = $signed(acc_base) >>> st_reg.shift;
        is_acc = (st_reg.mode != ADCC_MODE_BASIC);
        if (st_reg.mode == ADCC_MODE_LPF) begin
            sum_x = acc_x + samp_x - {acc_sh[ACC_W-1], acc_sh};
        end else begin
            sum_x = acc_x + samp_x;
        end
        acc_new = is_acc ? sum_x[ACC_W-1:0] : acc_base;
        ovf_now = is_acc && (sum_x[ACC_W] != sum_x[ACC_W-1]);
        if (!is_acc) begin
            cnt_new = cnt_base;
        end else if (cnt_base == `ADCC_CNT_MAX) begin
            cnt_new = cnt_base;
        end else begin
            cnt_new = cnt_base + 8'h01;
        end
        if (st_reg.mode == ADCC_MODE_LPF) begin
            fltr_new = acc_new;
        end else begin
            fltr_new = acc_new_shift(acc_new, st_reg.shift);
        end
        case (st_reg.mode)
            ADCC_MODE_BASIC,
            ADCC_MODE_ACCUM: test_ok = 1'b1;
            ADCC_MODE_AVG,
            ADCC_MODE_BURST,
            ADCC_MODE_LPF:   test_ok = (cnt_new >= st_reg.rpt);
            default:         test_ok = 1'b0;
        endcase

        // One update per completed conversion, then the threshold test
        if (CONV_DONE_I) begin
            st_next.res  = CONV_RESULT_I;
            st_next.prev = st_reg.res;
            st_next.acc  = acc_new;
            st_next.cnt  = cnt_new;
            if (is_acc) st_next.fltr = fltr_new;
            if (test_ok && $signed(fltr_new) > $signed(st_reg.thresh)) begin
                st_next.tif = 1'b1;
                st_next.irq = 1'b1;
                if (is_acc && ovf_now) st_next.ovf = 1'b1;
            end
            if (st_reg.mode == ADCC_MODE_BURST && cnt_new < st_reg.rpt)
                st_next.start = 1'b1;
        end

        // Read data, one cycle after the strobe
        if (RD_I) begin
            case (ADDR_I)
                `ADCC_OFF_CTRL:   st_next.rdata = {13'h0, st_reg.shift,
                                      2'h0, st_reg.cs, 3'h0, st_reg.rcsel,
                                      st_reg.dsen, st_reg.mode};
                `ADCC_OFF_RPT:    st_next.rdata = {24'h0, st_reg.rpt};
                `ADCC_OFF_THRESH: st_next.rdata = ext32(st_reg.thresh);
                `ADCC_OFF_STATUS: st_next.rdata = {30'h0, st_reg.ovf,
                                                   st_reg.tif};
                `ADCC_OFF_ACC:    st_next.rdata = ext32(st_reg.acc);
                `ADCC_OFF_CNT:    st_next.rdata = {24'h0, st_reg.cnt};
                `ADCC_OFF_FLTR:   st_next.rdata = ext32(st_reg.fltr);
                `ADCC_OFF_RES: begin
                    st_next.rdata[RES_W-1:0]     = st_reg.res;
                    st_next.rdata[16+RES_W-1:16] = st_reg.prev;
                end
                default:          st_next.rdata = 32'h0;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_reg       <= '0;
            st_reg.mode  <= ADCC_MODE_BASIC;
            st_reg.cs    <= `ADCC_RST_CS;
            st_reg.shift <= `ADCC_RST_SHIFT;
            st_reg.rpt   <= `ADCC_RST_RPT;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign RDATA_O       = st_reg.rdata;
    assign CONV_CLK_EN_O = st_reg.clk_en;
    assign CONV_START_O  = st_reg.start;
    assign THRESH_IRQ_O  = st_reg.irq;
    assign THRESH_FLAG_O = st_reg.tif;
    assign OVF_FLAG_O    = st_reg.ovf;

endmodule
`default_nettype wire

/* tb/adcc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_monitor
#(
    parameter int RES_W = 10,
    parameter int ACC_W = 18
) (
    input wire logic             CLK_SYS_I,
    input wire logic             NRST_I,
    input wire logic [7:0]       ADDR_I,
    input wire logic [31:0]      WDATA_I,
    input wire logic             WR_I,
    input wire logic             RD_I,
    input wire logic [31:0]      RDATA_O,
    input wire logic             RC_CLK_I,
    input wire logic             RETRIG_I,
    input wire logic             CONV_DONE_I,
    input wire logic [RES_W-1:0] CONV_RESULT_I,
    input wire logic             CONV_CLK_EN_O,
    input wire logic             CONV_START_O,
    input wire logic             THRESH_IRQ_O,
    input wire logic             THRESH_FLAG_O,
    input wire logic             OVF_FLAG_O
);
    // ****************************************************************
    // Protocol checks
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!NRST_I);
    // Go written to the control word
    sequence s_go;
        WR_I && ADDR_I == 8'h00 && WDATA_I[5];
    endsequence
    // Flag cleared by software
    sequence s_w1c;
        WR_I && ADDR_I == 8'h0c && WDATA_I[0];
    endsequence
    AST_CLKEN_GAP: assert property (CONV_CLK_EN_O |=> !CONV_CLK_EN_O)
        else $error("clock enable pulses too close");
    AST_GO_START: assert property (s_go |=> CONV_START_O)
        else $error("go did not start a conversion");
    AST_RETRIG_START: assert property (RETRIG_I |=> CONV_START_O)
        else $error("retrigger did not start a conversion");
    AST_START_CAUSE: assert property (CONV_START_O |->
        $past(WR_I) || $past(RETRIG_I) || $past(CONV_DONE_I))
        else $error("start without a cause");
    AST_IRQ_CAUSE: assert property (THRESH_IRQ_O |-> $past(CONV_DONE_I))
        else $error("interrupt without a conversion");
    AST_IRQ_FLAG: assert property (THRESH_IRQ_O |-> THRESH_FLAG_O)
        else $error("interrupt without flag");
    AST_FLAG_HOLD: assert property (THRESH_FLAG_O &&
        !(WR_I && ADDR_I == 8'h0c && WDATA_I[0]) |=> THRESH_FLAG_O)
        else $error("threshold flag dropped");
    AST_FLAG_CLEAR: assert property (s_w1c |=>
        !THRESH_FLAG_O || THRESH_IRQ_O)
        else $error("threshold flag not cleared");
    AST_OVF_AT_IRQ: assert property ($rose(OVF_FLAG_O) |-> THRESH_IRQ_O)
        else $error("overflow flag outside interrupt");
endmodule
bind adcc_core adcc_monitor #(.RES_W(RES_W), .ACC_W(ACC_W)) i_mon (
    .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .RC_CLK_I(RC_CLK_I), .RETRIG_I(RETRIG_I), .CONV_DONE_I(CONV_DONE_I),
    .CONV_RESULT_I(CONV_RESULT_I), .CONV_CLK_EN_O(CONV_CLK_EN_O),
    .CONV_START_O(CONV_START_O), .THRESH_IRQ_O(THRESH_IRQ_O),
    .THRESH_FLAG_O(THRESH_FLAG_O), .OVF_FLAG_O(OVF_FLAG_O));
`default_nettype wire

/* tb/adcc_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_conv_model
#(
    parameter int LAT = 4
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       start_i,
    input  wire logic [9:0] sample_i,
    output logic            done_o,
    output logic      [9:0] result_o
);
    int cnt;
    // Converts LAT cycles after start; result toggles when not valid
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
            result_o <= 10'h3ff;
        end else begin
            done_o <= 1'b0;
            result_o <= ~result_o;
            if (start_i) begin
                cnt <= LAT;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            if (cnt == 1 && !start_i) begin
                done_o <= 1'b1;
                result_o <= sample_i;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb_adcc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_core;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        rc = 1'b0, retrig = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [9:0]  smp = 10'h000, res;
    logic        done, clk_en, start, irq, tflag, oflag;
    int          n_mismatch = 0, n_tests = 0, cyc = 0, n_irq = 0;
    logic [5:0]  cs_tab [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h3f};
    int          div_tab [6] = '{2, 4, 6, 8, 16, 128};
    // ****************************************************************
    // Clocks, design and converter model
    // ****************************************************************
    always #4 clk = ~clk;
    initial begin
        #3;
        forever #500 rc = ~rc;
    end
    // Count interrupt pulses
    always @(negedge clk) begin
        if (irq === 1'b1) n_irq++;
    end
    adcc_core i_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .RC_CLK_I(rc), .RETRIG_I(retrig), .CONV_DONE_I(done),
        .CONV_RESULT_I(res), .CONV_CLK_EN_O(clk_en), .CONV_START_O(start),
        .THRESH_IRQ_O(irq), .THRESH_FLAG_O(tflag), .OVF_FLAG_O(oflag));
    adcc_conv_model i_conv (.clk_i(clk), .nrst_i(nrst), .start_i(start),
        .sample_i(smp), .done_o(done), .result_o(res));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task results;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
        n_tests++;
        if (seen !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, seen);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(n, rdata, e);
    endtask
    // Control word with clock select 0 and RC select off
    function logic [31:0] ctl(input logic [2:0] m, input logic ds, go, cl,
                              input logic [2:0] sh);
        return {13'h0, sh, 9'h0, cl, go, 1'b0, ds, m};
    endfunction
    task conv(input logic [2:0] m, input logic ds, input logic [2:0] sh,
              input logic [9:0] s);
        smp <= s;
        wreg(8'h00, ctl(m, ds, 1'b1, 1'b0, sh));
        repeat (40) @(posedge clk);
    endtask
    // Gap between enable pulses, first pulse skipped
    task per(input logic [5:0] cs, input logic r, input int e);
        int t;
        wreg(8'h00, {18'h0, cs, 3'h0, r, 4'h0});
        for (int k = 0; k < 3; k++) begin
            t = 0;
            @(negedge clk);
            while (clk_en !== 1'b1 && t < 400) begin
                @(negedge clk);
                t++;
            end
        end
        chk("clk_en period", t + 1, e);
    endtask
    // ****************************************************************
    // Watchdog and main sequence
    // ****************************************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rchk("cnt", 8'h14, 32'h0);
        rchk("unmapped", 8'h20, 32'h0);
        for (int i = 0; i < 6; i++) per(cs_tab[i], 1'b0, div_tab[i]);
        per(6'h00, 1'b1, 125);
        wreg(8'h08, 32'h0001ffff);
        wreg(8'h00, ctl(3'h1, 1'b0, 1'b0, 1'b1, 3'h0));
        conv(3'h1, 1'b0, 3'h0, 10'h005);
        conv(3'h1, 1'b0, 3'h0, 10'h007);
        rchk("acc", 8'h10, 32'h0000000c);
        rchk("cnt", 8'h14, 32'h2);
        wreg(8'h00, ctl(3'h1, 1'b0, 1'b0, 1'b1, 3'h0));
        rchk("cnt", 8'h14, 32'h0);
        conv(3'h0, 1'b0, 3'h0, 10'h009);
        rchk("acc", 8'h10, 32'h0);
        rchk("cnt", 8'h14, 32'h0);
        wreg(8'h04, 32'h4);
        conv(3'h3, 1'b0, 3'h2, 10'h00a);
        rchk("acc", 8'h10, 32'h00000028);
        rchk("cnt", 8'h14, 32'h4);
        rchk("fltr", 8'h18, 32'h0000000a);
        conv(3'h3, 1'b0, 3'h2, 10'h00a);
        rchk("acc", 8'h10, 32'h00000028);
        wreg(8'h00, ctl(3'h1, 1'b1, 1'b0, 1'b1, 3'h0));
        conv(3'h1, 1'b1, 3'h0, 10'h01e);
        conv(3'h1, 1'b1, 3'h0, 10'h032);
        rchk("acc", 8'h10, 32'h00000028);
        wreg(8'h00, ctl(3'h4, 1'b0, 1'b0, 1'b1, 3'h1));
        conv(3'h4, 1'b0, 3'h1, 10'h040);
        conv(3'h4, 1'b0, 3'h1, 10'h040);
        rchk("acc", 8'h10, 32'h00000060);
        wreg(8'h08, 32'h0);
        wreg(8'h04, 32'h2);
        wreg(8'h00, ctl(3'h2, 1'b0, 1'b0, 1'b1, 3'h0));
        conv(3'h2, 1'b0, 3'h0, 10'h003);
        rchk("status", 8'h0c, 32'h0);
        conv(3'h2, 1'b0, 3'h0, 10'h003);
        rchk("status", 8'h0c, 32'h1);
        conv(3'h2, 1'b0, 3'h0, 10'h003);
        rchk("acc", 8'h10, 32'h3);
        wreg(8'h0c, 32'h1);
        rchk("status", 8'h0c, 32'h0);
        @(posedge clk);
        retrig <= 1'b1;
        @(posedge clk);
        retrig <= 1'b0;
        repeat (40) @(posedge clk);
        rchk("cnt", 8'h14, 32'h2);
        wreg(8'h0c, 32'h3);
        wreg(8'h08, 32'h00020000);
        wreg(8'h04, 32'h81);
        wreg(8'h00, ctl(3'h3, 1'b0, 1'b0, 1'b1, 3'h0));
        conv(3'h3, 1'b0, 3'h0, 10'h3ff);
        repeat (800) @(posedge clk);
        rchk("status", 8'h0c, 32'h3);
        rchk("acc", 8'h10, 32'hfffe037f);
        rchk("cnt", 8'h14, 32'h81);
        chk("ovf pin", oflag, 1'b1);
        chk("flag pin", tflag, 1'b1);
        chk("irq count", n_irq, 3);
        results();
    end
endmodule
`default_nettype wire
